// ---- shared/crv_pkg.sv ----
package crv_pkg;

  // register indexes; byte address is four times the index
  localparam logic [5:0] IDX_INDIRECT  = 6'h00;
  localparam logic [5:0] IDX_BANK      = 6'h01;
  localparam logic [5:0] IDX_PC_LOW    = 6'h02;
  localparam logic [5:0] IDX_STATUS    = 6'h03;
  localparam logic [5:0] IDX_RAM_SEL   = 6'h04;
  localparam logic [5:0] IDX_PORT5     = 6'h05;
  localparam logic [5:0] IDX_PORT6     = 6'h06;
  localparam logic [5:0] IDX_PORT7     = 6'h07;
  localparam logic [5:0] IDX_PORT8     = 6'h08;
  localparam logic [5:0] IDX_PORT5_DIR = 6'h0b;
  localparam logic [5:0] IDX_CAUSE     = 6'h20;

  // software-writable bit masks
  localparam logic [7:0] MASK_BANK   = 8'h33;
  localparam logic [7:0] MASK_STATUS = 8'h87;
  localparam logic [7:0] MASK_PORT5  = 8'hdf;
  localparam logic [7:0] MASK_PORT7  = 8'hcf;
  localparam logic [7:0] MASK_PORT8  = 8'h01;

  // status field positions
  localparam int STAT_INT = 7;
  localparam int STAT_T   = 4;
  localparam int STAT_P   = 3;

  // reset values
  localparam logic [7:0] RST_INDIRECT  = 8'h00;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_RAM_SEL   = 8'hff;
  localparam logic [7:0] RST_STATUS    = 8'h18;
  localparam logic [7:0] RST_PORT5_DIR = 8'hdf;

  // last initial-value set that was loaded
  typedef enum logic [2:0] {
    CAUSE_POWER_ON = 3'b000,
    CAUSE_EXT_RUN  = 3'b001,
    CAUSE_EXT_WAKE = 3'b010,
    CAUSE_WDT_RUN  = 3'b011,
    CAUSE_WDT_WAKE = 3'b100,
    CAUSE_PIN_WAKE = 3'b101
  } crv_cause_t;

endpackage

// ---- hdl/crv_core_regs.sv ----
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
module crv_core_regs (
  // clock and power-on reset
  input  wire logic                CLK,
  input  wire logic                RST,
  // apb slave
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [7:0]          PADDR,
  input  wire logic [31:0]         PWDATA,
  output logic                     PREADY,
  output logic      [31:0]         PRDATA,
  output logic                     PSLVERR,
  // reset pin and core events
  input  wire logic                EXT_RESET_N,
  input  wire logic                WATCHDOG_TIMEOUT,
  input  wire logic                PIN_WAKE,
  input  wire logic                SLEEP_INSTRUCTION,
  input  wire logic                WATCHDOG_CLEAR_INSTRUCTION,
  // register contents toward the core
  output logic      [7:0]          INDIRECT_DATA_PORT,
  output logic      [7:0]          BANK_SELECTOR,
  output logic      [7:0]          PROGRAM_COUNTER_LOW,
  output logic      [7:0]          CPU_STATUS,
  output logic      [7:0]          RAM_SELECT_POINTER,
  output logic      [7:0]          PORT5_DATA,
  output logic      [7:0]          PORT6_DATA,
  output logic      [7:0]          PORT7_DATA,
  output logic      [7:0]          PORT8_DATA,
  output logic      [7:0]          PORT5_DIRECTION,
  output logic                     ASLEEP,
  output crv_pkg::crv_cause_t      LAST_CAUSE
);
  import crv_pkg::*;

  typedef struct packed {
    logic             ext_sync1;
    logic             ext_sync2;
    logic             asleep;
    crv_cause_t       cause;
    logic [7:0]       indirect;
    logic [7:0]       bank;
    logic [7:0]       pc_low;
    logic [7:0]       status;
    logic [7:0]       ram_sel;
    logic [7:0]       port5;
    logic [7:0]       port6;
    logic [7:0]       port7;
    logic [7:0]       port8;
    logic [7:0]       port5_dir;
    logic             pready;
    logic [31:0]      prdata;
    logic             pslverr;
  } crv_state_t;

  crv_state_t st;
  crv_state_t next_st;

  function automatic logic crv_hit(input logic [7:0] addr, input logic [5:0] idx);
    crv_hit = (addr[1:0] == 2'b00) && (addr[7:2] == idx);
  endfunction

  function automatic logic crv_mapped(input logic [7:0] addr);
    crv_mapped = crv_hit(addr, IDX_INDIRECT) || crv_hit(addr, IDX_BANK) ||
                 crv_hit(addr, IDX_PC_LOW) || crv_hit(addr, IDX_STATUS) ||
                 crv_hit(addr, IDX_RAM_SEL) || crv_hit(addr, IDX_PORT5) ||
                 crv_hit(addr, IDX_PORT6) || crv_hit(addr, IDX_PORT7) ||
                 crv_hit(addr, IDX_PORT8) || crv_hit(addr, IDX_PORT5_DIR) ||
                 crv_hit(addr, IDX_CAUSE);
  endfunction

  logic       ext_reset;
  logic       wdt_reset;
  logic       any_reset;
  logic       wr_en;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  always_comb begin
    next_st = st;
    ext_reset = ~st.ext_sync2;
    wdt_reset = WATCHDOG_TIMEOUT;
    any_reset = ext_reset | wdt_reset;
    wbyte = PWDATA[7:0];
    wr_en = PSEL & PENABLE & st.pready & PWRITE & ~st.pslverr;

    // pin is asynchronous, two flops before use
    next_st.ext_sync1 = EXT_RESET_N;
    next_st.ext_sync2 = st.ext_sync1;

    // apb: data and ready registered from the setup cycle, one wait-free access
    next_st.pready = PSEL & ~PENABLE & ~st.pready;
    next_st.pslverr = 1'b0;
    rbyte = 8'h00;
    if (crv_hit(PADDR, IDX_INDIRECT)) begin
      rbyte = st.indirect;
    end else if (crv_hit(PADDR, IDX_BANK)) begin
      rbyte = st.bank;
    end else if (crv_hit(PADDR, IDX_PC_LOW)) begin
      rbyte = st.pc_low;
    end else if (crv_hit(PADDR, IDX_STATUS)) begin
      rbyte = st.status;
    end else if (crv_hit(PADDR, IDX_RAM_SEL)) begin
      rbyte = st.ram_sel;
    end else if (crv_hit(PADDR, IDX_PORT5)) begin
      rbyte = st.port5;
    end else if (crv_hit(PADDR, IDX_PORT6)) begin
      rbyte = st.port6;
    end else if (crv_hit(PADDR, IDX_PORT7)) begin
      rbyte = st.port7;
    end else if (crv_hit(PADDR, IDX_PORT8)) begin
      rbyte = st.port8;
    end else if (crv_hit(PADDR, IDX_PORT5_DIR)) begin
      rbyte = st.port5_dir;
    end else if (crv_hit(PADDR, IDX_CAUSE)) begin
      rbyte = {4'h0, st.asleep, st.cause};
    end
    if (PSEL & ~PENABLE & ~st.pready) begin
      next_st.prdata = {24'h000000, rbyte};
      next_st.pslverr = ~crv_mapped(PADDR);
    end else begin
      // read data stands only while ready is high
      next_st.prdata = 32'h00000000;
    end

    // software writes; events below override them
    if (wr_en) begin
      if (crv_hit(PADDR, IDX_INDIRECT)) begin
        next_st.indirect = wbyte;
      end
      if (crv_hit(PADDR, IDX_BANK)) begin
        next_st.bank = wbyte & MASK_BANK;
      end
      if (crv_hit(PADDR, IDX_PC_LOW)) begin
        next_st.pc_low = wbyte;
      end
      // T and P are not software-writable
      if (crv_hit(PADDR, IDX_STATUS)) begin
        next_st.status = (wbyte & MASK_STATUS) | (st.status & ~MASK_STATUS);
      end
      if (crv_hit(PADDR, IDX_RAM_SEL)) begin
        next_st.ram_sel = wbyte;
      end
      if (crv_hit(PADDR, IDX_PORT5)) begin
        next_st.port5 = wbyte & MASK_PORT5;
      end
      if (crv_hit(PADDR, IDX_PORT6)) begin
        next_st.port6 = wbyte;
      end
      if (crv_hit(PADDR, IDX_PORT7)) begin
        next_st.port7 = wbyte & MASK_PORT7;
      end
      if (crv_hit(PADDR, IDX_PORT8)) begin
        next_st.port8 = wbyte & MASK_PORT8;
      end
      if (crv_hit(PADDR, IDX_PORT5_DIR)) begin
        next_st.port5_dir = wbyte & MASK_PORT5;
      end
    end

    if (WATCHDOG_CLEAR_INSTRUCTION) begin
      next_st.status[STAT_T] = 1'b1;
      next_st.status[STAT_P] = 1'b1;
    end
    if (SLEEP_INSTRUCTION) begin
      next_st.status[STAT_T] = 1'b1;
      next_st.status[STAT_P] = 1'b0;
      next_st.asleep = 1'b1;
    end

    if (any_reset) begin
      next_st.bank = RST_ZERO;
      next_st.pc_low = RST_ZERO;
      next_st.status[7:5] = 3'b000;
      next_st.port5 = RST_ZERO;
      next_st.port6 = RST_ZERO;
      next_st.port7 = RST_ZERO;
      next_st.port8 = RST_ZERO;
      next_st.port5_dir = RST_PORT5_DIR;
      next_st.asleep = 1'b0;
      if (ext_reset) begin
        // pin reset in sleep looks like a wake; running it keeps T and P
        if (st.asleep) begin
          next_st.status[STAT_T] = 1'b1;
          next_st.status[STAT_P] = 1'b0;
          next_st.cause = CAUSE_EXT_WAKE;
        end else begin
          next_st.status[STAT_T] = st.status[STAT_T];
          next_st.status[STAT_P] = st.status[STAT_P];
          next_st.cause = CAUSE_EXT_RUN;
        end
      end else begin
        next_st.status[STAT_T] = 1'b0;
        if (st.asleep) begin
          next_st.status[STAT_P] = 1'b0;
          next_st.cause = CAUSE_WDT_WAKE;
        end else begin
          next_st.status[STAT_P] = st.status[STAT_P];
          next_st.cause = CAUSE_WDT_RUN;
        end
      end
    end else if (PIN_WAKE & st.asleep) begin
      next_st.status[STAT_T] = 1'b1;
      next_st.status[STAT_P] = 1'b0;
      next_st.status[6:5] = 2'b00;
      next_st.asleep = 1'b0;
      next_st.cause = CAUSE_PIN_WAKE;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st.ext_sync1 <= 1'b1;
      st.ext_sync2 <= 1'b1;
      st.asleep <= 1'b0;
      st.cause <= CAUSE_POWER_ON;
      st.indirect <= RST_INDIRECT;
      st.bank <= RST_ZERO;
      st.pc_low <= RST_ZERO;
      // int clear, T and P set
      st.status <= RST_STATUS;
      st.ram_sel <= RST_RAM_SEL;
      st.port5 <= RST_ZERO;
      st.port6 <= RST_ZERO;
      st.port7 <= RST_ZERO;
      st.port8 <= RST_ZERO;
      st.port5_dir <= RST_PORT5_DIR;
      st.pready <= 1'b0;
      st.prdata <= 32'h00000000;
      st.pslverr <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign PREADY = st.pready;
  assign PRDATA = st.prdata;
  assign PSLVERR = st.pslverr;
  assign INDIRECT_DATA_PORT = st.indirect;
  assign BANK_SELECTOR = st.bank;
  assign PROGRAM_COUNTER_LOW = st.pc_low;
  assign CPU_STATUS = st.status;
  assign RAM_SELECT_POINTER = st.ram_sel;
  assign PORT5_DATA = st.port5;
  assign PORT6_DATA = st.port6;
  assign PORT7_DATA = st.port7;
  assign PORT8_DATA = st.port8;
  assign PORT5_DIRECTION = st.port5_dir;
  assign ASLEEP = st.asleep;
  assign LAST_CAUSE = st.cause;

endmodule

// ---- test/crv_core_regs_asserts.sv ----
`timescale 1ns/1ns
module crv_core_regs_asserts
  import crv_pkg::*;
(
  // clock, reset, bus handshake
  input wire logic                CLK,
  input wire logic                RST,
  input wire logic                PSEL,
  input wire logic                PENABLE,
  input wire logic                PREADY,
  // core events
  input wire logic                EXT_RESET_N,
  input wire logic                WATCHDOG_TIMEOUT,
  input wire logic                PIN_WAKE,
  input wire logic                SLEEP_INSTRUCTION,
  input wire logic                WATCHDOG_CLEAR_INSTRUCTION,
  // register contents
  input wire logic [7:0]          INDIRECT_DATA_PORT,
  input wire logic [7:0]          BANK_SELECTOR,
  input wire logic [7:0]          PROGRAM_COUNTER_LOW,
  input wire logic [7:0]          CPU_STATUS,
  input wire logic [7:0]          RAM_SELECT_POINTER,
  input wire logic [7:0]          PORT5_DATA,
  input wire logic [7:0]          PORT6_DATA,
  input wire logic [7:0]          PORT7_DATA,
  input wire logic [7:0]          PORT8_DATA,
  input wire logic [7:0]          PORT5_DIRECTION,
  input wire logic                ASLEEP,
  input wire crv_pkg::crv_cause_t LAST_CAUSE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  pon_values_a: assert property ($fell(RST) |-> RAM_SELECT_POINTER == 8'hff
    && CPU_STATUS[4:3] == 2'b11 && PORT5_DIRECTION == 8'hdf && LAST_CAUSE == CAUSE_POWER_ON)
    else $error("power-on values wrong");
  wdt_run_a: assert property (WATCHDOG_TIMEOUT && !ASLEEP && EXT_RESET_N |=>
    CPU_STATUS[4] == 1'b0 && CPU_STATUS[3] == $past(CPU_STATUS[3]) && CPU_STATUS[7:5] == 3'h0)
    else $error("running watchdog status wrong");
  wdt_wake_a: assert property (WATCHDOG_TIMEOUT && ASLEEP |=> CPU_STATUS[4:3] == 2'b00
    && !ASLEEP && LAST_CAUSE == CAUSE_WDT_WAKE) else $error("watchdog wake wrong");
  pin_wake_a: assert property (PIN_WAKE && ASLEEP && !WATCHDOG_TIMEOUT |=>
    CPU_STATUS[4:3] == 2'b10 && CPU_STATUS[7] == $past(CPU_STATUS[7]) && !ASLEEP)
    else $error("pin wake status wrong");
  sleep_flags_a: assert property (SLEEP_INSTRUCTION && !WATCHDOG_TIMEOUT |=>
    ASLEEP && CPU_STATUS[4:3] == 2'b10) else $error("sleep flags wrong");
  wdt_clear_a: assert property (WATCHDOG_CLEAR_INSTRUCTION && !WATCHDOG_TIMEOUT
    && !SLEEP_INSTRUCTION |=> CPU_STATUS[4:3] == 2'b11) else $error("clear flags wrong");
  wdt_keep_a: assert property (WATCHDOG_TIMEOUT |=> $stable(INDIRECT_DATA_PORT)
    && $stable(RAM_SELECT_POINTER) && BANK_SELECTOR == 8'h00 && PROGRAM_COUNTER_LOW == 8'h00)
    else $error("watchdog reset values wrong");
  ext_reset_a: assert property ($fell(EXT_RESET_N) |-> ##[2:4] (PORT6_DATA == 8'h00
    && PORT8_DATA == 8'h00 && PORT5_DIRECTION == 8'hdf)) else $error("pin reset values wrong");
  unimpl_zero_a: assert property (PORT5_DATA[5] == 1'b0 && PORT7_DATA[5:4] == 2'b00
    && PORT8_DATA[7:1] == 7'h00 && PORT5_DIRECTION[5] == 1'b0) else $error("reserved bit set");
  ready_pulse_a: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("ready pulse wrong");
endmodule

bind crv_core_regs crv_core_regs_asserts chk_u (.*);

// ---- test/crv_core_regs_bench.sv ----
`timescale 1ns/1ns
module crv_core_regs_bench;
  import crv_pkg::*;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [4:0]  evt = 5'h00;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'd68070;
  logic        pready, pslverr;
  logic [33:0] nt;
  logic [33:0] notes [$];
  logic [7:0]  sh [10];
  logic [5:0]  ix [10] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h0b};
  logic [7:0]  mk [10] = '{8'hff, 8'h33, 8'hff, 8'h87, 8'hff, 8'hdf, 8'hff, 8'hcf, 8'h01, 8'hdf};
  logic [7:0]  rs [10] = '{8'h00, 8'h00, 8'h00, 8'h18, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hdf};
  int          fail_count = 0, checked = 0;

  always #4 clk = ~clk;

  crv_core_regs dut_u (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .EXT_RESET_N(~evt[4]), .WATCHDOG_TIMEOUT(evt[0]), .PIN_WAKE(evt[1]),
    .SLEEP_INSTRUCTION(evt[2]), .WATCHDOG_CLEAR_INSTRUCTION(evt[3]),
    .INDIRECT_DATA_PORT(), .BANK_SELECTOR(), .PROGRAM_COUNTER_LOW(), .CPU_STATUS(),
    .RAM_SELECT_POINTER(), .PORT5_DATA(), .PORT6_DATA(), .PORT7_DATA(),
    .PORT8_DATA(), .PORT5_DIRECTION(), .ASLEEP(), .LAST_CAUSE());

  task automatic end_of_test();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    notes.push_back({w, e});
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      end_of_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // answer is taken at the rising edge that completes the access
  always @(posedge clk) begin
    if (pready === 1'b1 && psel === 1'b1 && penable === 1'b1) begin
      nt = notes.size() > 0 ? notes.pop_front() : 'x;
      cmp({pslverr, nt[33] ? 32'h0 : prdata}, nt[32:0]);
    end
  end

  task automatic chk(input crv_cause_t c);
    for (int i = 0; i < 10; i++)
      apb(1'b0, {ix[i], 2'b00}, 32'h0, {25'h0, sh[i]});
    apb(1'b0, 8'h80, 32'h0, {30'h0, c});
  endtask

  task automatic wr_all();
    logic [31:0] v;
    for (int i = 0; i < 10; i++) begin
      v = rnd();
      apb(1'b1, {ix[i], 2'b00}, v, 33'h0);
      sh[i] = (i == 3) ? (v[7:0] & 8'h87) | (sh[3] & 8'h18) : v[7:0] & mk[i];
    end
  endtask

  // one cycle only: a longer pin-reset low would repeat as a running reset
  task automatic pulse(input logic [4:0] v);
    @(posedge clk);
    evt <= v;
    @(posedge clk);
    evt <= 5'h00;
    repeat (5) @(posedge clk);
  endtask

  task automatic st(input logic [7:0] m, input logic [7:0] s);
    sh[3] = (sh[3] & m) | s;
  endtask

  task automatic rst_sh(input logic [7:0] m, input logic [7:0] s);
    for (int i = 1; i < 10; i++)
      if (i != 3 && i != 4)
        sh[i] = rs[i];
    st(m, s);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    sh = rs;
    chk(CAUSE_POWER_ON);
    apb(1'b1, 8'h24, 32'h5a, {1'b1, 32'h0});
    apb(1'b0, 8'h05, 32'h0, {1'b1, 32'h0});
    wr_all();
    chk(CAUSE_POWER_ON);
    wr_all();
    pulse(5'h01);
    rst_sh(8'h0f, 8'h00);
    chk(CAUSE_WDT_RUN);
    wr_all();
    pulse(5'h08);
    st(8'hff, 8'h18);
    chk(CAUSE_WDT_RUN);
    wr_all();
    pulse(5'h04);
    pulse(5'h02);
    st(8'h87, 8'h10);
    chk(CAUSE_PIN_WAKE);
    wr_all();
    pulse(5'h10);
    rst_sh(8'h1f, 8'h00);
    chk(CAUSE_EXT_RUN);
    wr_all();
    pulse(5'h04);
    pulse(5'h10);
    rst_sh(8'h07, 8'h10);
    chk(CAUSE_EXT_WAKE);
    wr_all();
    pulse(5'h04);
    pulse(5'h03);
    rst_sh(8'h07, 8'h00);
    chk(CAUSE_WDT_WAKE);
    wr_all();
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    sh = rs;
    chk(CAUSE_POWER_ON);
    end_of_test();
  end
endmodule
